// [src/accessory_irq_defines.vh]
/*
 * register offsets, field positions, reset values and timing figures
 * for the accessory event flag and timing block.
 * assumes inclusion by bare name from the design file.
 */
`ifndef ACCESSORY_IRQ_DEFINES_VH
`define ACCESSORY_IRQ_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte register port)
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h02
`define OFS_EVENT_FLAGS_FIRST 8'h03
`define OFS_EVENT_FLAGS_SECOND 8'h04
`define OFS_EVENT_BLOCK_FIRST 8'h05
`define OFS_EVENT_BLOCK_SECOND 8'h06
`define OFS_ID_RESISTANCE_CODE 8'h07
`define OFS_WAKE_AND_PRESS_TIMING 8'h08
`define OFS_LONG_PRESS_AND_SWITCH_DELAY 8'h09

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_EVENT_FLAGS 8'h00
`define RST_EVENT_BLOCK 8'h00
`define RST_ID_CODE 5'h00
`define RST_TIMING 8'h00
`define RST_CONTROL 8'h0b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_ATTACH 0
`define BIT_DETACH 1
`define BIT_KEY_PRESSED 2
`define BIT_LONG_PRESS 3
`define BIT_LONG_RELEASE 4
`define BIT_OVERVOLTAGE 5
`define BIT_OVERTEMP 6
`define BIT_PROT_CLEARED 7
`define BIT_AV_CHARGING 0
`define BIT_UNKNOWN_ACC 1
`define BIT_CODE_CHANGE 2
`define BIT_STUCK_KEY 3
`define BIT_STUCK_RECOVERED 4
`define SECOND_USED_BITS 5
`define CTRL_MASTER_MASK 0
`define CTRL_WAIT 1
`define CTRL_RAW_REPORT 3
`define CTRL_USED_MASK 8'h0b

// ----------------------------------------------------------------
// timing figures, milliseconds unless noted
// ----------------------------------------------------------------
`define CORE_CLK_KHZ 200000
`define MS_TICK_CYCLES (`CORE_CLK_KHZ * 1)
// sized to the 11-bit duration and 4-bit code fields they meet
`define WAKE_SHORT_STEP_MS 11'h032
`define WAKE_LONG_STEP_MS 11'h064
`define WAKE_MAX_CODE 4'hb
`define PRESS_STEP_MS 11'h064
`define PRESS_MAX_CODE 4'h9
`define LONG_BASE_MS 11'h12c
`define LONG_STEP_MS 11'h064
`define LONG_MAX_CODE 4'hc
`define SWITCH_BASE_MS 11'h00a
`define SWITCH_STEP_MS 11'h014
`define SWITCH_MAX_CODE 4'ha

`endif

// [src/accessory_event_irq_and_timing.v]
/*
 * event flags, event blocks, id resistance code, timing settings,
 * key monitor, periodic sampling and switch delay of the accessory
 * detection logic.
 * assumes a serial front end that presents one byte register access
 * per strobe, detection pulses on core_clk, and pin levels that are
 * asynchronous and so pass two flip-flops here.
 */
`timescale 1ns/1ps
`include "accessory_irq_defines.vh"

// Operation
// - attach, detach, key press set bits 0-2
// - long key hold sets first bit 3
// - release after long press sets bit 4
// - supply overvoltage sets first bit 5
// - die overtemperature sets first bit 6
// - protection condition removed sets bit 7
// - charger with av cable sets second bit 0
// - unclassified accessory sets second bit 1
// - code change sets bit 2 in periodic mode
// - stuck key bit 3, recovery bit 4
// - block bit one keeps flag off interrupt
// - five bit read-only id code, reset zero
// - sample id at wake-up period
// - periodic conversions at wake-up period
// - long press after programmed long duration
// - switch close delayed by programmed wait
// - master mask blocks interrupt, resets set
// - raw select one runs key monitor
// - wait bit selects delayed or host close
// - full timing code tables with saturation
module accessory_event_irq_and_timing #(
    parameter MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
    input wire core_clk,
    input wire rst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire attach_evt,
    input wire detach_evt,
    input wire av_charger_evt,
    input wire unknown_acc_evt,
    input wire stuck_key_evt,
    input wire held_button_recovered_evt,
    input wire low_power_mode,
    input wire key_pin,
    input wire overvoltage_pin,
    input wire overtemp_pin,
    input wire [4:0] id_code_pin,
    output reg host_irq_pin,
    output reg id_sample,
    output reg switch_close
);

    // ------------------------------------------------------------
    // lookup of programmed durations
    // ------------------------------------------------------------
    // codes past the table end saturate at the longest setting
    function [10:0] wake_ms;
        input [3:0] code;
        reg [3:0] c;
        begin
            c = (code > `WAKE_MAX_CODE) ? `WAKE_MAX_CODE : code;
            if (c < 4'd4) begin
                wake_ms = `WAKE_SHORT_STEP_MS * ({7'h00, c} + 11'h001);
            end else begin
                wake_ms = `WAKE_LONG_STEP_MS * ({7'h00, c} - 11'h001);
            end
        end
    endfunction

    function [10:0] press_ms;
        input [3:0] code;
        reg [3:0] c;
        begin
            c = (code > `PRESS_MAX_CODE) ? `PRESS_MAX_CODE : code;
            press_ms = `PRESS_STEP_MS * ({7'h00, c} + 11'h001);
        end
    endfunction

    function [10:0] long_ms;
        input [3:0] code;
        reg [3:0] c;
        begin
            c = (code > `LONG_MAX_CODE) ? `LONG_MAX_CODE : code;
            long_ms = `LONG_BASE_MS + `LONG_STEP_MS * {7'h00, c};
        end
    endfunction

    function [10:0] switch_ms;
        input [3:0] code;
        reg [3:0] c;
        begin
            c = (code > `SWITCH_MAX_CODE) ? `SWITCH_MAX_CODE : code;
            switch_ms = `SWITCH_BASE_MS + `SWITCH_STEP_MS * {7'h00, c};
        end
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg [1:0] key_sync_q;
    reg [1:0] ovp_sync_q;
    reg [1:0] otp_sync_q;
    reg [4:0] code_meta_q;
    reg [4:0] code_sync_q;
    reg ovp_prev_q;
    reg otp_prev_q;
    reg key_prev_q;
    reg [7:0] flags1_q;
    reg [7:0] flags1_d;
    reg [4:0] flags2_q;
    reg [4:0] flags2_d;
    reg [7:0] block1_q;
    reg [4:0] block2_q;
    reg [4:0] id_code_q;
    reg [7:0] timing1_q;
    reg [7:0] timing2_q;
    reg [7:0] control_q;
    reg [17:0] tick_cnt_q;
    reg ms_tick_q;
    reg [10:0] wake_cnt_q;
    reg [10:0] key_cnt_q;
    reg long_seen_q;
    reg [10:0] sw_cnt_q;
    reg sw_pending_q;
    reg [7:0] set1;
    reg [4:0] set2;
    wire master_mask = control_q[`CTRL_MASTER_MASK];
    wire wait_bit = control_q[`CTRL_WAIT];
    wire raw_report = control_q[`CTRL_RAW_REPORT];
    wire key_level = key_sync_q[1];
    wire wake_due = ms_tick_q && (wake_cnt_q + 11'h001 >= wake_ms(timing1_q[3:0]));
    wire key_press_hit = ms_tick_q && (key_cnt_q + 11'h001 == press_ms(timing1_q[7:4]));
    wire key_long_hit = ms_tick_q && (key_cnt_q + 11'h001 == long_ms(timing2_q[3:0]));
    wire rd_flags1 = reg_rd && (reg_addr == `OFS_EVENT_FLAGS_FIRST);
    wire rd_flags2 = reg_rd && (reg_addr == `OFS_EVENT_FLAGS_SECOND);
    wire code_sample = wake_due && !raw_report;
    wire [7:0] pend1 = flags1_q & ~block1_q;
    wire [4:0] pend2 = flags2_q & ~block2_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // the first stage is read only by the second stage
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_sync_q <= 2'b00;
            ovp_sync_q <= 2'b00;
            otp_sync_q <= 2'b00;
            code_meta_q <= 5'h00;
            code_sync_q <= 5'h00;
            ovp_prev_q <= 1'b0;
            otp_prev_q <= 1'b0;
            key_prev_q <= 1'b0;
        end else begin
            key_sync_q <= {key_sync_q[0], key_pin};
            ovp_sync_q <= {ovp_sync_q[0], overvoltage_pin};
            otp_sync_q <= {otp_sync_q[0], overtemp_pin};
            code_meta_q <= id_code_pin;
            code_sync_q <= code_meta_q;
            ovp_prev_q <= ovp_sync_q[1];
            otp_prev_q <= otp_sync_q[1];
            key_prev_q <= key_level;
        end
    end

    // ------------------------------------------------------------
    // millisecond time base and wake-up period
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 18'h00000;
            ms_tick_q <= 1'b0;
            wake_cnt_q <= 11'h000;
        end else begin
            ms_tick_q <= (tick_cnt_q == MS_TICK_CYCLES[17:0] - 18'h00001);
            if (tick_cnt_q == MS_TICK_CYCLES[17:0] - 18'h00001) begin
                tick_cnt_q <= 18'h00000;
            end else begin
                tick_cnt_q <= tick_cnt_q + 18'h00001;
            end
            if (wake_due) begin
                wake_cnt_q <= 11'h000;
            end else if (ms_tick_q) begin
                wake_cnt_q <= wake_cnt_q + 11'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // id sampling and converter result
    // ------------------------------------------------------------
    // a sample strobe goes out in low power modes and in periodic mode
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            id_sample <= 1'b0;
            id_code_q <= `RST_ID_CODE;
        end else begin
            id_sample <= wake_due && (low_power_mode || !raw_report);
            if (code_sample) begin
                id_code_q <= code_sync_q;
            end
        end
    end

    // ------------------------------------------------------------
    // key monitor, active only with raw select set
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_cnt_q <= 11'h000;
            long_seen_q <= 1'b0;
        end else begin
            if (!raw_report || !key_level) begin
                key_cnt_q <= 11'h000;
            end else if (ms_tick_q && key_cnt_q != 11'h7ff) begin
                key_cnt_q <= key_cnt_q + 11'h001; // saturates on a stuck key
            end
            if (!raw_report) begin
                long_seen_q <= 1'b0;
            end else if (key_long_hit && key_level) begin
                long_seen_q <= 1'b1;
            end else if (!key_level) begin
                long_seen_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // event set terms
    // ------------------------------------------------------------
    always @* begin
        set1 = 8'h00;
        set2 = 5'h00;
        set1[`BIT_ATTACH] = attach_evt;
        set1[`BIT_DETACH] = detach_evt;
        set1[`BIT_KEY_PRESSED] = raw_report && key_level && key_press_hit;
        set1[`BIT_LONG_PRESS] = raw_report && key_level && key_long_hit;
        set1[`BIT_LONG_RELEASE] = raw_report && long_seen_q && key_prev_q && !key_level;
        set1[`BIT_OVERVOLTAGE] = ovp_sync_q[1] && !ovp_prev_q;
        set1[`BIT_OVERTEMP] = otp_sync_q[1] && !otp_prev_q;
        set1[`BIT_PROT_CLEARED] = (ovp_prev_q || otp_prev_q)
            && !ovp_sync_q[1] && !otp_sync_q[1];
        set2[`BIT_AV_CHARGING] = av_charger_evt;
        set2[`BIT_UNKNOWN_ACC] = unknown_acc_evt;
        set2[`BIT_CODE_CHANGE] = code_sample && (code_sync_q != id_code_q);
        set2[`BIT_STUCK_KEY] = stuck_key_evt;
        set2[`BIT_STUCK_RECOVERED] = held_button_recovered_evt;
    end

    // read clears, but a set in the same cycle survives
    always @* begin
        flags1_d = (rd_flags1 ? 8'h00 : flags1_q) | set1;
        flags2_d = (rd_flags2 ? 5'h00 : flags2_q) | set2;
    end

    // ------------------------------------------------------------
    // registers, register port and interrupt
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags1_q <= `RST_EVENT_FLAGS;
            flags2_q <= 5'h00;
            block1_q <= `RST_EVENT_BLOCK;
            block2_q <= 5'h00;
            timing1_q <= `RST_TIMING;
            timing2_q <= `RST_TIMING;
            control_q <= `RST_CONTROL;
            reg_rdata <= 8'h00;
            host_irq_pin <= 1'b0;
        end else begin
            flags1_q <= flags1_d;
            flags2_q <= flags2_d;
            // irq drops one cycle after the clearing read
            host_irq_pin <= !master_mask && ((|pend1) || (|pend2));
            if (reg_wr) begin
                if (reg_addr == `OFS_CONTROL) begin
                    control_q <= reg_wdata & `CTRL_USED_MASK;
                end else if (reg_addr == `OFS_EVENT_BLOCK_FIRST) begin
                    block1_q <= reg_wdata;
                end else if (reg_addr == `OFS_EVENT_BLOCK_SECOND) begin
                    block2_q <= reg_wdata[4:0];
                end else if (reg_addr == `OFS_WAKE_AND_PRESS_TIMING) begin
                    timing1_q <= reg_wdata;
                end else if (reg_addr == `OFS_LONG_PRESS_AND_SWITCH_DELAY) begin
                    timing2_q <= reg_wdata;
                end
            end
            if (reg_rd) begin
                if (reg_addr == `OFS_CONTROL) begin
                    reg_rdata <= control_q;
                end else if (reg_addr == `OFS_EVENT_FLAGS_FIRST) begin
                    reg_rdata <= flags1_q;
                end else if (reg_addr == `OFS_EVENT_FLAGS_SECOND) begin
                    reg_rdata <= {3'b000, flags2_q};
                end else if (reg_addr == `OFS_EVENT_BLOCK_FIRST) begin
                    reg_rdata <= block1_q;
                end else if (reg_addr == `OFS_EVENT_BLOCK_SECOND) begin
                    reg_rdata <= {3'b000, block2_q};
                end else if (reg_addr == `OFS_ID_RESISTANCE_CODE) begin
                    reg_rdata <= {3'b000, id_code_q};
                end else if (reg_addr == `OFS_WAKE_AND_PRESS_TIMING) begin
                    reg_rdata <= timing1_q;
                end else if (reg_addr == `OFS_LONG_PRESS_AND_SWITCH_DELAY) begin
                    reg_rdata <= timing2_q;
                end else begin
                    reg_rdata <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // switch close delay
    // ------------------------------------------------------------
    // a pending switch close waits while the master mask is set; a closed switch stays closed until a detach event
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_cnt_q <= 11'h000;
            sw_pending_q <= 1'b0;
            switch_close <= 1'b0;
        end else begin
            if (detach_evt) begin
                sw_pending_q <= 1'b0;
                switch_close <= 1'b0;
                sw_cnt_q <= 11'h000;
            end else if (attach_evt) begin
                sw_pending_q <= 1'b1;
                sw_cnt_q <= 11'h000;
            end else if (sw_pending_q && !master_mask) begin
                if (!wait_bit) begin
                    sw_cnt_q <= 11'h000; // held for the host
                end else if (sw_cnt_q >= switch_ms(timing2_q[7:4])) begin
                    switch_close <= 1'b1;
                    sw_pending_q <= 1'b0;
                end else if (ms_tick_q) begin
                    sw_cnt_q <= sw_cnt_q + 11'h001;
                end
            end
        end
    end

endmodule // accessory_event_irq_and_timing

// [verification/accessory_irq_props.sv]
/* checker for the accessory event block: interrupt, readback, sampling
   and switch relations built on shadows of host writes.
   assumes binding to the top module; sees only its ports. */
`timescale 1ns/1ps
module accessory_irq_props #(
    parameter MS_TICK_CYCLES = 10
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic attach_evt,
    input wire logic low_power_mode,
    input wire logic host_irq_pin,
    input wire logic id_sample,
    input wire logic switch_close
);
    // ------------------------------------------------------------
    // shadows of host writes
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] blk1_q;
    logic [7:0] tim1_q;

    // shadows let reads be predicted without peeking inside
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 8'h0b;
            blk1_q <= 8'h00;
            tim1_q <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                8'h02: ctrl_q <= reg_wdata & 8'h0b;
                8'h05: blk1_q <= reg_wdata;
                8'h08: tim1_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_open_attach;
        attach_evt && !reg_wr && !ctrl_q[0] && !blk1_q[0];
    endsequence
    property p_attach_irq;
        s_open_attach |-> ##[1:3] host_irq_pin;
    endproperty
    a_attach_irq: assert property (p_attach_irq)
        else $error("open attach did not raise irq");
    property p_mask_hold;
        ctrl_q[0] && $past(ctrl_q[0]) |-> !host_irq_pin;
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("irq high under master mask");
    property p_reserved;
        reg_rd && reg_addr inside {8'h04, 8'h06, 8'h07} |=> reg_rdata[7:5] == 3'b000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits read nonzero");
    property p_ctrl_rd;
        reg_rd && reg_addr == 8'h02 |=> reg_rdata == $past(ctrl_q);
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("control readback wrong");
    property p_blk1_rd;
        reg_rd && reg_addr == 8'h05 |=> reg_rdata == $past(blk1_q);
    endproperty
    a_blk1_rd: assert property (p_blk1_rd)
        else $error("block readback wrong");
    property p_tim1_rd;
        reg_rd && reg_addr == 8'h08 |=> reg_rdata == $past(tim1_q);
    endproperty
    a_tim1_rd: assert property (p_tim1_rd)
        else $error("timing readback wrong");
    property p_raw_quiet;
        ctrl_q[3] && $past(ctrl_q[3]) && !low_power_mode && !$past(low_power_mode)
            |-> !id_sample;
    endproperty
    a_raw_quiet: assert property (p_raw_quiet)
        else $error("sample pulse in key monitor mode");
    property p_switch_wait;
        !ctrl_q[1] && !$past(ctrl_q[1]) && !$past(switch_close) |-> !switch_close;
    endproperty
    a_switch_wait: assert property (p_switch_wait)
        else $error("switch closed while waiting for host");
endmodule // accessory_irq_props

bind accessory_event_irq_and_timing accessory_irq_props #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES)
) i_props (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .attach_evt(attach_evt),
    .low_power_mode(low_power_mode),
    .host_irq_pin(host_irq_pin),
    .id_sample(id_sample),
    .switch_close(switch_close)
);

// [verification/host_model.sv]
/* host side model: byte register writes and reads on the strobe port.
   assumes core_clk of the device; callers use its tasks in turn. */
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // idle strobes from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // released lines show inverted data so stale values are not trusted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // answer taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

    // master mask cleared before any event flag read
    task automatic open_irq(input logic [7:0] ctrl);
        wr(8'h02, ctrl & 8'hfe);
    endtask
endmodule // host_model

// [verification/tb.sv]
/* self-checking bench for the accessory event block.
   assumes the host model drives the register port; 1 ms = 10 cycles. */
`timescale 1ns/1ps
module tb;
    logic core_clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic [5:0] evt;
    logic key_pin;
    logic overvoltage_pin;
    logic overtemp_pin;
    logic [4:0] id_code_pin;
    logic low_power_mode;
    logic host_irq_pin;
    logic id_sample;
    logic switch_close;
    logic [7:0] seen;
    int err_total;
    int tests_run;
    int pulses;
    // rows: address, data written, value read back
    logic [23:0] rows [0:6] = '{24'h08a5a5, 24'h093c3c, 24'h05ffff, 24'h06ff1f,
        24'h02ff0b, 24'h07ff00, 24'h00ff00};

    // 200 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    host_model i_host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    // short ms tick keeps long key counts affordable
    accessory_event_irq_and_timing #(.MS_TICK_CYCLES(10)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .attach_evt(evt[0]),
        .detach_evt(evt[1]), .av_charger_evt(evt[2]), .unknown_acc_evt(evt[3]),
        .stuck_key_evt(evt[4]), .held_button_recovered_evt(evt[5]),
        .low_power_mode(low_power_mode), .key_pin(key_pin), .overvoltage_pin(overvoltage_pin),
        .overtemp_pin(overtemp_pin), .id_code_pin(id_code_pin), .host_irq_pin(host_irq_pin),
        .id_sample(id_sample), .switch_close(switch_close));

    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, seen);
        chk(name, seen, exp);
    endtask

    task automatic pulse(input logic [5:0] v);
        @(posedge core_clk);
        evt <= v;
        @(posedge core_clk);
        evt <= 6'h00;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog well past the expected seven thousand cycles
    initial begin
        #(30000 * 5);
        err_total++;
        $display("mismatch watchdog expected done seen timeout");
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        evt = 6'h00;
        key_pin = 1'b0;
        overvoltage_pin = 1'b0;
        overtemp_pin = 1'b0;
        id_code_pin = 5'h00;
        low_power_mode = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            i_host.wr(rows[i][23:16], rows[i][15:8]);
            rdchk("readback", rows[i][23:16], rows[i][7:0]);
        end
        // second reset in mid-run restores defaults
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rdchk("reset ctrl", 8'h02, 8'h0b);
        for (int a = 5; a <= 9; a++) begin
            rdchk("reset reg", a[7:0], 8'h00);
        end
        i_host.open_irq(8'h0b);
        pulse(6'h3f);
        repeat (4) @(posedge core_clk);
        chk("irq", {7'h00, host_irq_pin}, 8'h01);
        rdchk("flags1", 8'h03, 8'h03);
        rdchk("flags2", 8'h04, 8'h1b);
        rdchk("flags1 cleared", 8'h03, 8'h00);
        repeat (2) @(posedge core_clk);
        chk("irq low", {7'h00, host_irq_pin}, 8'h00);
        // blocked attach keeps its flag but not the pin
        i_host.wr(8'h05, 8'h01);
        pulse(6'h01);
        repeat (4) @(posedge core_clk);
        chk("irq blocked", {7'h00, host_irq_pin}, 8'h00);
        rdchk("blocked flag", 8'h03, 8'h01);
        i_host.wr(8'h05, 8'h00);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            {overtemp_pin, overvoltage_pin} <= 2'b01 << k;
            repeat (6) @(posedge core_clk);
            {overtemp_pin, overvoltage_pin} <= 2'b00;
            repeat (6) @(posedge core_clk);
            rdchk("protection", 8'h03, 8'h80 | (8'h20 << k));
        end
        // key held past press then long press, then released
        @(posedge core_clk);
        key_pin <= 1'b1;
        repeat (900) @(posedge core_clk);
        rdchk("short hold", 8'h03, 8'h00);
        repeat (1900) @(posedge core_clk);
        rdchk("press", 8'h03, 8'h04);
        repeat (400) @(posedge core_clk);
        key_pin <= 1'b0;
        repeat (20) @(posedge core_clk);
        rdchk("long", 8'h03, 8'h18);
        // periodic conversion mode
        id_code_pin <= 5'h05;
        i_host.open_irq(8'h02);
        repeat (1100) @(posedge core_clk);
        rdchk("id code", 8'h07, 8'h05);
        rdchk("code change", 8'h04, 8'h04);
        pulses = 0;
        repeat (1000) begin
            @(posedge core_clk);
            #1 if (id_sample === 1'b1) pulses++;
        end
        chk("samples", pulses[7:0], 8'h02);
        // host-released switching, then programmed wait
        i_host.open_irq(8'h08);
        pulse(6'h02);
        pulse(6'h01);
        repeat (300) @(posedge core_clk);
        chk("held open", {7'h00, switch_close}, 8'h00);
        i_host.open_irq(8'h0a);
        repeat (85) @(posedge core_clk);
        chk("still open", {7'h00, switch_close}, 8'h00);
        repeat (30) @(posedge core_clk);
        chk("closed", {7'h00, switch_close}, 8'h01);
        // standby sampling runs even with the key monitor selected
        low_power_mode <= 1'b1;
        pulses = 0;
        repeat (1000) begin
            @(posedge core_clk);
            #1 if (id_sample === 1'b1) pulses++;
        end
        chk("standby samples", pulses[7:0], 8'h02);
        finish_test();
    end
endmodule // tb
